// ==== rtl/remote_io_signal_router.sv ====
`timescale 1ns/10ps
`default_nettype none
module remote_io_signal_router
    import remote_io_pkg::*;
#(
    parameter int N = NUM_REMOTE
) (
    input  wire logic               clk,
    input  wire logic               srst,
    input  wire logic               ce,
    input  wire logic [N-1:0]       remote_in,
    input  wire code_t [N-1:0]      in_code,
    input  wire logic               out_code_we,
    input  wire logic [3:0]         out_code_idx,
    input  wire code_t              out_code_wdata,
    input  wire logic               three_wire_mode,
    input  wire status_t            status,
    output logic [N-1:0]            remote_out,
    output code_t [N-1:0]           out_code,
    output func_t                   funcs,
    output three_wire_t             three_wire,
    output logic                    fault_clear_pulse,
    output logic                    information_flag_clear_pulse,
    output logic                    ext_stop_alarm,
    output logic                    motor_run,
    output logic                    reverse_run,
    output logic                    run_brake
);

    // Any input carrying this code is ON
    function automatic logic any_on(input logic [N-1:0] v, input code_t [N-1:0] c,
                                    input code_t f);
        logic r;
        r = 1'b0;
        for (int i = 0; i < N; i++) begin
            if (c[i] == f && c[i] != CODE_NONE && v[i])
                r = 1'b1;
        end
        return r;
    endfunction : any_on

    // All inputs carrying this code are ON; unassigned reads ON
    function automatic logic all_on(input logic [N-1:0] v, input code_t [N-1:0] c,
                                    input code_t f);
        logic r;
        r = 1'b1;
        for (int i = 0; i < N; i++) begin
            if (c[i] == f && !v[i])
                r = 1'b0;
        end
        return r;
    endfunction : all_on

    code_t [N-1:0] next_out_code;
    func_t         next_funcs;
    logic          prev_fault_clr;
    logic          prev_information_clear_request;
    logic          next_fault_pulse;
    logic          next_information_flag_pulse;
    logic          prev_ext;
    logic          next_ext_alarm;
    logic [N-1:0]  mux_out;
    logic [N-1:0]  next_remote_out;

    // Output function selection table
    always_comb begin
        next_out_code = out_code;
        if (out_code_we && 32'(out_code_idx) < N)
            next_out_code[out_code_idx] = out_code_wdata;
    end

    always_ff @(posedge clk) begin
        if (srst)
            out_code <= OUT_MAP_RESET[N-1:0];
        else if (ce)
            out_code <= next_out_code;
    end

    // Input decode
    always_comb begin
        next_funcs                           = '0;
        next_funcs.fault_clear_request       = any_on(remote_in, in_code, CODE_FAULT_CLR);
        next_funcs.information_clear_request = any_on(remote_in, in_code, CODE_INFORMATION_CLEAR_REQUEST);
        next_funcs.tool_limit_release        = all_on(remote_in, in_code, CODE_TOOL_REL);
        next_funcs.torque_limiting_enable    = all_on(remote_in, in_code, CODE_TORQUE_EN);
        next_funcs.external_stop_input       = 1'b1;
        next_funcs.forward_run_cmd           = any_on(remote_in, in_code, CODE_FWD);
        next_funcs.reverse_run_cmd           = any_on(remote_in, in_code, CODE_REV);
        next_funcs.stop_mode_cmd             = any_on(remote_in, in_code, CODE_STOP_MODE);
        next_funcs.data_select[0]            = any_on(remote_in, in_code, CODE_SEL0);
        next_funcs.data_select[1]            = any_on(remote_in, in_code, CODE_SEL1);
        next_funcs.data_select[2]            = any_on(remote_in, in_code, CODE_SEL2);
        next_fault_pulse = next_funcs.fault_clear_request & ~prev_fault_clr;
        next_information_flag_pulse  = next_funcs.information_clear_request & ~prev_information_clear_request;
        // A new stop event wins over a fault clear in the same cycle
        next_ext_alarm   = (ext_stop_alarm & ~next_fault_pulse)
                         | (prev_ext & ~next_funcs.external_stop_input);
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            funcs             <= FUNCS_RESET;
            prev_fault_clr    <= 1'b0;
            prev_information_clear_request     <= 1'b0;
            prev_ext          <= 1'b1;
            fault_clear_pulse <= 1'b0;
            information_flag_clear_pulse  <= 1'b0;
            ext_stop_alarm    <= 1'b0;
        end else if (ce) begin
            funcs             <= next_funcs;
            prev_fault_clr    <= next_funcs.fault_clear_request;
            prev_information_clear_request     <= next_funcs.information_clear_request;
            prev_ext          <= next_funcs.external_stop_input;
            fault_clear_pulse <= next_fault_pulse;
            information_flag_clear_pulse  <= next_information_flag_pulse;
            ext_stop_alarm    <= next_ext_alarm;
        end
    end

    // Mode dependent views of the command inputs
    always_comb begin
        three_wire.start_stop = three_wire_mode & funcs.forward_run_cmd;
        three_wire.run_brake  = three_wire_mode & funcs.reverse_run_cmd;
        three_wire.fwd_rev    = three_wire_mode & funcs.stop_mode_cmd;
        motor_run   = three_wire_mode ? (funcs.forward_run_cmd & funcs.reverse_run_cmd)
                                      : (funcs.forward_run_cmd | funcs.reverse_run_cmd);
        motor_run   = motor_run & ~ext_stop_alarm;
        reverse_run = three_wire_mode ? ~funcs.stop_mode_cmd
                                      : (funcs.reverse_run_cmd & ~funcs.forward_run_cmd);
        run_brake   = three_wire_mode & funcs.reverse_run_cmd;
    end

    for (genvar g = 0; g < N; g++) begin : g_out
        remote_out_mux u_mux (
            .code   (out_code[g]),
            .funcs  (funcs),
            .status (status),
            .value  (mux_out[g])
        );
    end

    always_comb begin
        next_remote_out = mux_out;
    end

    always_ff @(posedge clk) begin
        if (srst)
            remote_out <= '0;
        else if (ce)
            remote_out <= next_remote_out;
    end

    // Checks on the registered outputs and on the combinational motor_run
    a_fault_edge: assert property (@(posedge clk) disable iff (srst)
        ce && next_funcs.fault_clear_request && !funcs.fault_clear_request |=> fault_clear_pulse)
        else $error("fault clear edge missed");
    a_information_flag_edge: assert property (@(posedge clk) disable iff (srst)
        ce && next_funcs.information_clear_request && !funcs.information_clear_request
        |=> information_flag_clear_pulse)
        else $error("information_flag clear edge missed");
    a_pulse_single: assert property (@(posedge clk) disable iff (srst)
        ce && fault_clear_pulse |=> !fault_clear_pulse)
        else $error("fault clear pulse longer than one cycle");
    a_information_flag_single: assert property (@(posedge clk) disable iff (srst)
        ce && information_flag_clear_pulse |=> !information_flag_clear_pulse)
        else $error("information_flag clear pulse longer than one cycle");
    a_code_write: assert property (@(posedge clk) disable iff (srst)
        ce && out_code_we && out_code_idx == 4'h0 |=> out_code[0] == $past(out_code_wdata))
        else $error("output code write lost");
    a_freeze_state: assert property (@(posedge clk) disable iff (srst)
        !ce |=> $stable(out_code) && $stable(funcs) && $stable(remote_out))
        else $error("state changed while enable low");
    a_unused_in: assert property (@(posedge clk) disable iff (srst)
        ce && in_code == '0 |=> funcs == FUNCS_RESET)
        else $error("unassigned inputs drive a function");
    a_three_brake: assert property (@(posedge clk) disable iff (srst)
        three_wire_mode && !funcs.reverse_run_cmd |-> !motor_run)
        else $error("motor runs while braked");
    a_fwd_runs: assert property (@(posedge clk) disable iff (srst)
        !three_wire_mode && funcs.forward_run_cmd && !ext_stop_alarm |-> motor_run)
        else $error("forward command does not run motor");
    a_ext_always: assert property (@(posedge clk) disable iff (srst)
        funcs.external_stop_input)
        else $error("external stop not ON");
    a_zero_out: assert property (@(posedge clk) disable iff (srst)
        ce && out_code[0] == CODE_NONE |=> !remote_out[0])
        else $error("unassigned output not OFF");
    a_echo_sel0: assert property (@(posedge clk) disable iff (srst)
        ce && out_code[0] == CODE_SEL0 |=> remote_out[0] == $past(funcs.data_select[0]))
        else $error("echo mismatch");
    a_run_stop: assert property (@(posedge clk) disable iff (srst)
        !three_wire_mode && !funcs.forward_run_cmd && !funcs.reverse_run_cmd |-> !motor_run)
        else $error("motor runs without command");
    a_tool_all: assert property (@(posedge clk) disable iff (srst)
        ce && in_code[0] == CODE_TOOL_REL && !remote_in[0] |=> !funcs.tool_limit_release)
        else $error("tool release with input off");
    a_torque_all: assert property (@(posedge clk) disable iff (srst)
        ce && in_code[1] == CODE_TORQUE_EN && !remote_in[1] |=> !funcs.torque_limiting_enable)
        else $error("torque enable with input off");
    c_fault_clr: cover property (@(posedge clk) fault_clear_pulse);
    c_information_clear_request:  cover property (@(posedge clk) information_flag_clear_pulse);
    c_three:     cover property (@(posedge clk) three_wire_mode && motor_run);
    c_write:     cover property (@(posedge clk) ce && out_code_we);
    c_zero_code: cover property (@(posedge clk) out_code[0] == CODE_NONE);
endmodule : remote_io_signal_router
`default_nettype wire

// ==== rtl/remote_io_pkg.sv ====
package remote_io_pkg;

    localparam int NUM_REMOTE = 16;
    localparam int CODE_W     = 8;

    typedef logic [CODE_W-1:0] code_t;

    // Input function codes
    localparam code_t CODE_NONE       = 8'h00;
    localparam code_t CODE_FAULT_CLR  = 8'h08;
    localparam code_t CODE_INFORMATION_CLEAR_REQUEST   = 8'h0e;
    localparam code_t CODE_TOOL_REL   = 8'h10;
    localparam code_t CODE_TORQUE_EN  = 8'h16;
    localparam code_t CODE_EXT_STOP   = 8'h19;
    localparam code_t CODE_FWD        = 8'h3a;
    localparam code_t CODE_REV        = 8'h3b;
    localparam code_t CODE_SEL0       = 8'h40;
    localparam code_t CODE_SEL1       = 8'h41;
    localparam code_t CODE_SEL2       = 8'h42;
    localparam code_t CODE_STOP_MODE  = 8'h48;
    // Status output codes
    localparam code_t CODE_FAULT      = 8'h81;
    localparam code_t CODE_MOVING     = 8'h86;
    localparam code_t CODE_INFORMATION_FLAG       = 8'h87;
    localparam code_t CODE_BUSY       = 8'h88;
    localparam code_t CODE_TQ_LIMITED = 8'h8c;
    localparam code_t CODE_SPEED_OK   = 8'h8d;
    localparam code_t CODE_DIRECTION  = 8'h94;
    localparam code_t CODE_MAIN_POWER = 8'ha8;

    typedef code_t [NUM_REMOTE-1:0] code_map_t;

    // Factory output map, index 0 is remote output zero
    localparam code_map_t OUT_MAP_RESET = '{
        CODE_TQ_LIMITED, CODE_SPEED_OK, CODE_MOVING, CODE_NONE, CODE_NONE,
        CODE_MAIN_POWER, CODE_DIRECTION, CODE_BUSY, CODE_FAULT, CODE_INFORMATION_FLAG,
        CODE_STOP_MODE, CODE_REV, CODE_FWD, CODE_SEL2, CODE_SEL1, CODE_SEL0};

    // Internal status flags from the driver core
    typedef struct packed {
        logic information_flag;
        logic fault_flag;
        logic system_busy_flag;
        logic direction_flag;
        logic main_power_status;
        logic moving_flag;
        logic speed_reached_flag;
        logic torque_limited_flag;
    } status_t;

    // Decoded input functions
    typedef struct packed {
        logic       fault_clear_request;
        logic       information_clear_request;
        logic       tool_limit_release;
        logic       torque_limiting_enable;
        logic       external_stop_input;
        logic       forward_run_cmd;
        logic       reverse_run_cmd;
        logic       stop_mode_cmd;
        logic [2:0] data_select;
    } func_t;

    // Decoded functions while every input is unassigned
    localparam func_t FUNCS_RESET = '{fault_clear_request: 1'b0,
                                      information_clear_request: 1'b0,
                                      tool_limit_release: 1'b1,
                                      torque_limiting_enable: 1'b1,
                                      external_stop_input: 1'b1,
                                      forward_run_cmd: 1'b0,
                                      reverse_run_cmd: 1'b0,
                                      stop_mode_cmd: 1'b0,
                                      data_select: 3'h0};

    // Three-wire view of the same command inputs
    typedef struct packed {
        logic start_stop;
        logic run_brake;
        logic fwd_rev;
    } three_wire_t;

endpackage : remote_io_pkg

// ==== rtl/remote_out_mux.sv ====
`timescale 1ns/10ps
`default_nettype none
module remote_out_mux
    import remote_io_pkg::*;
(
    input  wire code_t   code,
    input  wire func_t   funcs,
    input  wire status_t status,
    output logic         value
);
    // One output bit selected by its assignment code
    always_comb begin
        case (code)
            CODE_FAULT_CLR:  value = funcs.fault_clear_request;
            CODE_INFORMATION_CLEAR_REQUEST:   value = funcs.information_clear_request;
            CODE_TOOL_REL:   value = funcs.tool_limit_release;
            CODE_TORQUE_EN:  value = funcs.torque_limiting_enable;
            CODE_EXT_STOP:   value = funcs.external_stop_input;
            CODE_FWD:        value = funcs.forward_run_cmd;
            CODE_REV:        value = funcs.reverse_run_cmd;
            CODE_STOP_MODE:  value = funcs.stop_mode_cmd;
            CODE_SEL0:       value = funcs.data_select[0];
            CODE_SEL1:       value = funcs.data_select[1];
            CODE_SEL2:       value = funcs.data_select[2];
            CODE_FAULT:      value = status.fault_flag;
            CODE_MOVING:     value = status.moving_flag;
            CODE_INFORMATION_FLAG:       value = status.information_flag;
            CODE_BUSY:       value = status.system_busy_flag;
            CODE_TQ_LIMITED: value = status.torque_limited_flag;
            CODE_SPEED_OK:   value = status.speed_reached_flag;
            CODE_DIRECTION:  value = status.direction_flag;
            CODE_MAIN_POWER: value = status.main_power_status;
            default:         value = 1'b0;
        endcase
    end
endmodule : remote_out_mux
`default_nettype wire

// ==== dv/remote_host_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module remote_host_model (
    input  wire logic        clk,
    output logic [15:0]      remote_in
);
    initial remote_in = '0;

    // Level update of all remote input bits just after a falling edge
    task automatic hold(input logic [15:0] v);
        @(negedge clk);
        remote_in = v;
    endtask : hold

    // OFF for one sampled edge, then ON, so the device sees a rising edge
    task automatic request_edge(input int b);
        @(negedge clk);
        remote_in[b] = 1'b0;
        @(negedge clk);
        remote_in[b] = 1'b1;
    endtask : request_edge
endmodule : remote_host_model
`default_nettype wire

// ==== dv/tb_remote_io_signal_router.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb_remote_io_signal_router
    import remote_io_pkg::*;
;
    logic         clk = 1'b0;
    logic         srst, ce, we, tw, fpl, ipl, alarm, mrun, rrun, rbrk;
    logic [3:0]   idx;
    code_t        wd, c;
    logic [15:0]  rin, rout, v, eo;
    code_t [15:0] in_code, ocode, exp_map;
    status_t      st;
    func_t        fo, f;
    three_wire_t  tw3;
    int           seed, mismatches, n_tests, k, i, j;
    localparam code_t CT [21] = '{CODE_NONE, CODE_FAULT_CLR, CODE_INFORMATION_CLEAR_REQUEST, CODE_TOOL_REL,
        CODE_TORQUE_EN, CODE_EXT_STOP, CODE_FWD, CODE_REV, CODE_SEL0, CODE_SEL1, CODE_SEL2,
        CODE_STOP_MODE, CODE_FAULT, CODE_MOVING, CODE_INFORMATION_FLAG, CODE_BUSY, CODE_TQ_LIMITED,
        CODE_SPEED_OK, CODE_DIRECTION, CODE_MAIN_POWER, 8'h05};

    remote_host_model i_remote_host_model (.clk(clk), .remote_in(rin));
    remote_io_signal_router #(.N(16)) i_remote_io_signal_router (
        .clk(clk), .srst(srst), .ce(ce), .remote_in(rin), .in_code(in_code),
        .out_code_we(we), .out_code_idx(idx), .out_code_wdata(wd), .three_wire_mode(tw),
        .status(st), .remote_out(rout), .out_code(ocode), .funcs(fo), .three_wire(tw3),
        .fault_clear_pulse(fpl), .information_flag_clear_pulse(ipl), .ext_stop_alarm(alarm),
        .motor_run(mrun), .reverse_run(rrun), .run_brake(rbrk));

    always #2.5 clk = ~clk;

    function automatic func_t exp_funcs(input logic [15:0] r, input code_t [15:0] cd);
        func_t e;
        e = '0;
        e.tool_limit_release = 1'b1;
        e.torque_limiting_enable = 1'b1;
        e.external_stop_input = 1'b1;
        for (int n = 0; n < 16; n++) begin
            case (cd[n])
                CODE_FAULT_CLR: e.fault_clear_request |= r[n];
                CODE_INFORMATION_CLEAR_REQUEST:  e.information_clear_request |= r[n];
                CODE_TOOL_REL:  e.tool_limit_release &= r[n];
                CODE_TORQUE_EN: e.torque_limiting_enable &= r[n];
                CODE_FWD:       e.forward_run_cmd |= r[n];
                CODE_REV:       e.reverse_run_cmd |= r[n];
                CODE_STOP_MODE: e.stop_mode_cmd |= r[n];
                CODE_SEL0:      e.data_select[0] |= r[n];
                CODE_SEL1:      e.data_select[1] |= r[n];
                CODE_SEL2:      e.data_select[2] |= r[n];
                default: ;
            endcase
        end
        return e;
    endfunction : exp_funcs

    function automatic logic exp_bit(input code_t cd, input func_t e, input status_t s);
        logic [0:20] vals;
        vals = {1'b0, e.fault_clear_request, e.information_clear_request,
            e.tool_limit_release, e.torque_limiting_enable, e.external_stop_input,
            e.forward_run_cmd, e.reverse_run_cmd, e.data_select, e.stop_mode_cmd,
            s.fault_flag, s.moving_flag, s.information_flag, s.system_busy_flag,
            s.torque_limited_flag, s.speed_reached_flag, s.direction_flag,
            s.main_power_status, 1'b0};
        vals[8:10] = {e.data_select[0], e.data_select[1], e.data_select[2]};
        for (int t = 0; t < 21; t++) begin
            if (cd == CT[t]) return vals[t];
        end
        return 1'b0;
    endfunction : exp_bit

    task automatic check(input logic [127:0] seen, input logic [127:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic close_out();
        $display("comparisons=%0d mismatches=%0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : close_out

    task automatic check_reset();
        f = '0;
        f.tool_limit_release = 1'b1;
        f.torque_limiting_enable = 1'b1;
        f.external_stop_input = 1'b1;
        check(128'(ocode), 128'(OUT_MAP_RESET));
        check(128'(rout), 128'h0);
        check(128'(fo), 128'(f));
        check(128'({fpl, ipl, alarm}), 128'h0);
    endtask : check_reset

    task automatic check_all();
        f = exp_funcs(v, in_code);
        for (i = 0; i < 16; i++) eo[i] = exp_bit(exp_map[i], f, st);
        check(128'(ocode), 128'(exp_map));
        check(128'(fo), 128'(f));
        check(128'(rout), 128'(eo));
        check(128'(alarm), 128'h0);
        check(128'(tw3), 128'({3{tw}} &
            {f.forward_run_cmd, f.reverse_run_cmd, f.stop_mode_cmd}));
        if (tw) check(128'({mrun, rrun, rbrk}), 128'({f.forward_run_cmd & f.reverse_run_cmd,
            ~f.stop_mode_cmd, f.reverse_run_cmd}));
        else check(128'({mrun, rrun, rbrk}), 128'({f.forward_run_cmd | f.reverse_run_cmd,
            f.reverse_run_cmd & ~f.forward_run_cmd, 1'b0}));
    endtask : check_all

    initial begin
        #400000;
        mismatches++;
        close_out();
    end

    initial begin
        seed = 67372;
        {srst, ce, we, tw, idx, wd, st, in_code} = {4'b1100, 4'h0, 8'h00, 8'h00, 128'h0};
        exp_map = OUT_MAP_RESET;
        repeat (4) @(negedge clk);
        check_reset();
        srst = 1'b0;
        $display("test reset done");
        for (k = 0; k < 40; k++) begin
            v = (k == 1) ? 16'hffff : 16'($random(seed));
            i_remote_host_model.hold(v);
            for (i = 0; i < 16; i++) in_code[i] = CT[$unsigned($random(seed)) % 12];
            if (k == 0) in_code = {{8{CODE_NONE}}, CODE_FAULT_CLR, CODE_NONE, CODE_STOP_MODE,
                CODE_REV, CODE_FWD, CODE_SEL2, CODE_SEL1, CODE_SEL0};
            st = (k == 1) ? 8'hff : status_t'(8'($random(seed)));
            tw = 1'($random(seed));
            idx = (k == 2) ? 4'h0 : 4'($random(seed));
            wd = (k == 2) ? CODE_NONE : CT[$unsigned($random(seed)) % 21];
            we = (k != 0);
            if (k != 0) exp_map[idx] = wd;
            @(negedge clk);
            we = 1'b0;
            repeat (2) @(negedge clk);
            check_all();
        end
        $display("test routing done");
        for (j = 0; j < 2; j++) begin
            c = j ? CODE_INFORMATION_CLEAR_REQUEST : CODE_FAULT_CLR;
            i_remote_host_model.hold(16'h0000);
            in_code = '0;
            in_code[3] = c;
            in_code[9] = c;
            repeat (2) @(negedge clk);
            i_remote_host_model.request_edge(3);
            @(negedge clk);
            check(128'(j ? ipl : fpl), 128'h1);
            repeat (4) @(negedge clk);
            check(128'(j ? ipl : fpl), 128'h0);
            i_remote_host_model.request_edge(9);
            @(negedge clk);
            check(128'({fpl, ipl}), 128'h0);
        end
        $display("test clear edges done");
        ce = 1'b0;
        {we, idx, wd} = {1'b1, 4'hb, CODE_FAULT};
        @(negedge clk);
        {we, ce} = 2'b01;
        @(negedge clk);
        check(128'(ocode), 128'(exp_map));
        srst = 1'b1;
        repeat (2) @(negedge clk);
        check_reset();
        srst = 1'b0;
        $display("test second reset done");
        close_out();
    end
endmodule : tb_remote_io_signal_router
`default_nettype wire
